/* ddcn_map.vh */
// Function
// - bypass output latency is 424 device clocks with the 8224 link parameter set.
// - an enabled down-converter adds decimation delay to the bypass latency.
// - each decimation option has its own fixed total latency in device clocks.
// - multiplexer mode feeds channel A samples into both channel paths.
// - multiplexer mode lets channel B power down; one input feeds four chains.
// - multiplexer mode keeps decimation and link format settings unchanged.
// - per channel, first converter has three oscillators, second has one.
// - real samples are multiplied by the active complex exponential.
// - oscillator step is a signed 16-bit word; frequency is word*fs/65536.
// - decimation by 4 or 6 allows only one down-converter per channel.
// - oscillator changes while the link runs leave phase undetermined.
// - bypass mode powers down all oscillators.
// - hopping works in single and dual band, only on the first converter.
// - per-channel bit picks hop selection from register (default) or pins.
// - route code 00 picks pin 4, 01 pin 1, 10 pin 3, 11 pin 2.
// - selection 00 is oscillator one, 01 two, 10 three, 11 unassigned.
// - all oscillators keep running; output after a switch is invalid until flushed.
`ifndef DDCN_MAP_VH
`define DDCN_MAP_VH
`define ADDR_A_SRC 15'h500f
`define ADDR_A_CHOICE 15'h5010
`define ADDR_A_PINMAP 15'h5438
`define ADDR_B_SRC 15'h580f
`define ADDR_B_CHOICE 15'h5810
`define ADDR_B_PINMAP 15'h5c38
`define ADDR_DEC 15'h5001
`define ADDR_MUX 15'h5002
`define ADDR_A_FREQ 15'h5020
`define ADDR_B_FREQ 15'h5820
`define FREQ_MASK 15'h7ff8
`define SPI_ADDR_BITS 5'h10
`define SPI_LAST_BIT 5'h17
`define SYNC_RST 8'h20
`define SEL_NONE 2'h3
// latencies held as twice the printed device-clock figure
`define LAT_BYP_X2 12'h350
`define LAT_D4_X2 12'h408
`define LAT_D6_X2 12'h5d4
`define LAT_D8_X2 12'h4da
`define LAT_D9_X2 12'h5f7
`define LAT_D10_X2 12'h656
`define LAT_D12_X2 12'h702
`define LAT_D16_X2 12'h82a
`define LAT_D18_X2 12'h918
`define LAT_D20_X2 12'h9d0
`define LAT_D24_X2 12'hb46
`define LAT_D32_X2 12'hdda
`define PIPE_CYC 11'h006
// the first ring entries after reset carry pipeline reset values, not samples
`define RING_WARM 11'h002
`define DEC_DIV8 4'h3
`define OUT_MSB 23
`define OUT_LSB 12
`endif

/* ddcn_top.v */
`include "ddcn_map.vh"
`default_nettype none
module ddcn_fifo #(
  parameter W = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire sys_clk,
  input wire resetn,
  input wire inValid,
  input wire [W-1:0] inData,
  output reg inReady,
  output reg outValid,
  output reg [W-1:0] outData,
  input wire outReady
);
  localparam [AW:0] FULLCNT = DEPTH;
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  wire [AW:0] cnt_nxt;
  assign push = inValid & inReady;
  assign pop = (cnt_r != {(AW+1){1'b0}}) & (~outValid | outReady);
  assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  // storage write
  always @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end
  // pointers, count and output register
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      inReady <= 1'b0;
      outValid <= 1'b0;
      outData <= {W{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
      inReady <= (cnt_nxt != FULLCNT);
      if (push) begin
        wrPtr_r <= wrPtr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        outData <= mem[rdPtr_r];
        outValid <= 1'b1;
        rdPtr_r <= rdPtr_r + {{(AW-1){1'b0}}, 1'b1};
      end else if (outReady) begin
        outValid <= 1'b0;
      end
    end
  end
endmodule // ddcn_fifo

module ddcn_top (
  input wire sys_clk,
  input wire resetn,
  input wire spiSclk,
  input wire spiSenN,
  input wire spiSdin,
  output reg spiSdout,
  output reg spiSdoutEn,
  input wire [3:0] gpioPin,
  input wire linkInit,
  input wire [13:0] adcA,
  input wire [13:0] adcB,
  input wire linkReady,
  output wire [95:0] linkData,
  output wire linkValid,
  output wire streamReady,
  output reg chBPowerDown
);
  integer i;
  // route code to pin index (pin n sits at bit n-1)
  function [1:0] pinOf;
    input [1:0] code;
    case (code)
      2'h0: pinOf = 2'h3;
      2'h1: pinOf = 2'h0;
      2'h2: pinOf = 2'h2;
      default: pinOf = 2'h1;
    endcase
  endfunction
  // decimation factor, zero for bypass
  function [5:0] decFactor;
    input [3:0] code;
    case (code)
      4'h1: decFactor = 6'h04;
      4'h2: decFactor = 6'h06;
      4'h3: decFactor = 6'h08;
      4'h4: decFactor = 6'h09;
      4'h5: decFactor = 6'h0a;
      4'h6: decFactor = 6'h0c;
      4'h7: decFactor = 6'h10;
      4'h8: decFactor = 6'h12;
      4'h9: decFactor = 6'h14;
      4'ha: decFactor = 6'h18;
      4'hb: decFactor = 6'h20;
      default: decFactor = 6'h00;
    endcase
  endfunction
  // total latency per option, in half clocks
  function [11:0] latX2;
    input [3:0] code;
    case (code)
      4'h1: latX2 = `LAT_D4_X2;
      4'h2: latX2 = `LAT_D6_X2;
      4'h3: latX2 = `LAT_D8_X2;
      4'h4: latX2 = `LAT_D9_X2;
      4'h5: latX2 = `LAT_D10_X2;
      4'h6: latX2 = `LAT_D12_X2;
      4'h7: latX2 = `LAT_D16_X2;
      4'h8: latX2 = `LAT_D18_X2;
      4'h9: latX2 = `LAT_D20_X2;
      4'ha: latX2 = `LAT_D24_X2;
      4'hb: latX2 = `LAT_D32_X2;
      default: latX2 = `LAT_BYP_X2;
    endcase
  endfunction
  // cos and negated sin of exp(-jwn), eight phase points
  function [15:0] loOf;
    input [2:0] ph;
    case (ph)
      3'h0: loOf = {8'h7f, 8'h00};
      3'h1: loOf = {8'h5a, 8'ha6};
      3'h2: loOf = {8'h00, 8'h81};
      3'h3: loOf = {8'ha6, 8'ha6};
      3'h4: loOf = {8'h81, 8'h00};
      3'h5: loOf = {8'ha6, 8'h5a};
      3'h6: loOf = {8'h00, 8'h7f};
      default: loOf = {8'h5a, 8'h5a};
    endcase
  endfunction
  // signed sample times signed oscillator value
  function signed [21:0] mix;
    input signed [13:0] s;
    input signed [7:0] k;
    mix = s * k;
  endfunction
  // frequency byte decode: {hit, channel, oscillator, high byte}
  function [4:0] freqIdx;
    input [14:0] a;
    if ((a & `FREQ_MASK) == `ADDR_A_FREQ)
      freqIdx = {2'h2, a[2:0]};
    else if ((a & `FREQ_MASK) == `ADDR_B_FREQ)
      freqIdx = {2'h3, a[2:0]};
    else
      freqIdx = 5'h00;
  endfunction

  // two-stage synchronisers for the gpio, serial and link-init pins
  reg [7:0] syncA_r;
  reg [7:0] syncB_r;
  reg sclkDly_r;
  wire [7:0] pinsRaw;
  assign pinsRaw = {linkInit, spiSdin, spiSenN, spiSclk, gpioPin};
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      syncA_r <= `SYNC_RST;
      syncB_r <= `SYNC_RST;
      sclkDly_r <= 1'b0;
    end else begin
      syncA_r <= pinsRaw;
      syncB_r <= syncA_r;
      sclkDly_r <= syncB_r[4];
    end
  end
  wire sclkRise;
  wire sclkFall;
  wire spiSel;
  wire initS;
  wire [3:0] gpioS;
  assign sclkRise = syncB_r[4] & ~sclkDly_r;
  assign sclkFall = ~syncB_r[4] & sclkDly_r;
  assign spiSel = ~syncB_r[5];
  assign initS = syncB_r[7];
  assign gpioS = syncB_r[3:0];

  // serial register port: read flag, 15-bit address, 8-bit data
  reg [4:0] bitCnt_r;
  reg [23:0] shift_r;
  reg [7:0] rdShift_r;
  reg [7:0] rdData;
  wire wrStb;
  wire [14:0] wrAddr;
  wire [7:0] wrData;
  assign wrStb = spiSel & sclkRise & (bitCnt_r == `SPI_LAST_BIT) & ~shift_r[22];
  assign wrAddr = shift_r[21:7];
  assign wrData = {shift_r[6:0], syncB_r[6]};
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bitCnt_r <= 5'h00;
      shift_r <= 24'h000000;
      rdShift_r <= 8'h00;
      spiSdout <= 1'b0;
      spiSdoutEn <= 1'b0;
    end else if (!spiSel) begin
      bitCnt_r <= 5'h00;
      spiSdoutEn <= 1'b0;
    end else if (sclkRise) begin
      shift_r <= {shift_r[22:0], syncB_r[6]};
      bitCnt_r <= bitCnt_r + 5'h01;
    end else if (sclkFall && bitCnt_r == `SPI_ADDR_BITS && shift_r[15]) begin
      spiSdout <= rdData[7];
      rdShift_r <= {rdData[6:0], 1'b0};
      spiSdoutEn <= 1'b1;
    end else if (sclkFall && spiSdoutEn) begin
      spiSdout <= rdShift_r[7];
      rdShift_r <= {rdShift_r[6:0], 1'b0};
    end
  end

  // register file
  reg [7:0] srcSel_r [0:1];
  reg [7:0] choice_r [0:1];
  reg [7:0] pinMap_r [0:1];
  reg [15:0] freq_r [0:7];
  reg [7:0] dec_r;
  reg [7:0] mux_r;
  wire [4:0] wIdx;
  assign wIdx = freqIdx(wrAddr);
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 2; i = i + 1) begin
        srcSel_r[i] <= 8'h00;
        choice_r[i] <= 8'h00;
        pinMap_r[i] <= 8'h00;
      end
      for (i = 0; i < 8; i = i + 1) begin
        freq_r[i] <= 16'h0000;
      end
      dec_r <= 8'h00;
      mux_r <= 8'h00;
    end else if (wrStb) begin
      case (wrAddr)
        `ADDR_A_SRC: srcSel_r[0] <= wrData;
        `ADDR_A_CHOICE: choice_r[0] <= wrData;
        `ADDR_A_PINMAP: pinMap_r[0] <= wrData;
        `ADDR_B_SRC: srcSel_r[1] <= wrData;
        `ADDR_B_CHOICE: choice_r[1] <= wrData;
        `ADDR_B_PINMAP: pinMap_r[1] <= wrData;
        `ADDR_DEC: dec_r <= wrData;
        `ADDR_MUX: mux_r <= wrData;
        default: begin
          if (wIdx[4] && wIdx[0])
            freq_r[wIdx[3:1]][15:8] <= wrData;
          else if (wIdx[4])
            freq_r[wIdx[3:1]][7:0] <= wrData;
        end
      endcase
    end
  end

  // read-back, including the live oscillator in use
  reg [1:0] active_r [0:1];
  wire [4:0] rIdx;
  assign rIdx = freqIdx(shift_r[14:0]);
  always @* begin
    case (shift_r[14:0])
      `ADDR_A_SRC: rdData = srcSel_r[0];
      `ADDR_A_CHOICE: rdData = {choice_r[0][7:4], 2'h0, active_r[0]};
      `ADDR_A_PINMAP: rdData = pinMap_r[0];
      `ADDR_B_SRC: rdData = srcSel_r[1];
      `ADDR_B_CHOICE: rdData = {choice_r[1][7:4], 2'h0, active_r[1]};
      `ADDR_B_PINMAP: rdData = pinMap_r[1];
      `ADDR_DEC: rdData = dec_r;
      `ADDR_MUX: rdData = mux_r;
      default: begin
        if (rIdx[4] && rIdx[0])
          rdData = freq_r[rIdx[3:1]][15:8];
        else if (rIdx[4])
          rdData = freq_r[rIdx[3:1]][7:0];
        else
          rdData = 8'h00;
      end
    endcase
  end

  // mode decode
  wire [5:0] factor;
  wire bypass;
  wire dualOk;
  wire muxMode;
  assign factor = decFactor(dec_r[3:0]);
  assign bypass = (factor == 6'h00);
  assign dualOk = (dec_r[3:0] >= `DEC_DIV8);
  assign muxMode = mux_r[0];

  // hop selection for the first converter of each channel
  reg [1:0] reqSel [0:1];
  reg [1:0] flush_r;
  reg [1:0] switched;
  integer j;
  always @* begin
    for (j = 0; j < 2; j = j + 1) begin
      if (srcSel_r[j][0])
        reqSel[j] = {gpioS[pinOf(pinMap_r[j][3:2])], gpioS[pinOf(pinMap_r[j][1:0])]};
      else
        reqSel[j] = choice_r[j][1:0];
      switched[j] = (reqSel[j] != `SEL_NONE) && (reqSel[j] != active_r[j]);
    end
  end
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      active_r[0] <= 2'h0;
      active_r[1] <= 2'h0;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        if (switched[i])
          active_r[i] <= reqSel[i];
      end
    end
  end

  // oscillator phase accumulators, running except in bypass or link init
  reg [15:0] phase_r [0:7];
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 8; i = i + 1) begin
        phase_r[i] <= 16'h0000;
      end
    end else begin
      for (i = 0; i < 8; i = i + 1) begin
        if (bypass || initS)
          phase_r[i] <= 16'h0000;
        else
          phase_r[i] <= phase_r[i] + freq_r[i];
      end
    end
  end

  // stage 1: sample capture and oscillator lookup
  reg [13:0] samp_r [0:1];
  reg [15:0] lo_r [0:3];
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      samp_r[0] <= 14'h0000;
      samp_r[1] <= 14'h0000;
      for (i = 0; i < 4; i = i + 1) begin
        lo_r[i] <= 16'h0000;
      end
    end else begin
      samp_r[0] <= adcA;
      samp_r[1] <= muxMode ? adcA : adcB;
      for (i = 0; i < 2; i = i + 1) begin
        lo_r[2*i] <= loOf(phase_r[4*i+active_r[i]][15:13]);
        lo_r[2*i+1] <= dualOk ? loOf(phase_r[4*i+3][15:13]) : 16'h0000;
      end
    end
  end

  // stage 2: complex mixing
  reg [21:0] prodI_r [0:3];
  reg [21:0] prodQ_r [0:3];
  reg [13:0] sampD_r [0:1];
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        prodI_r[i] <= 22'h000000;
        prodQ_r[i] <= 22'h000000;
      end
      sampD_r[0] <= 14'h0000;
      sampD_r[1] <= 14'h0000;
    end else begin
      sampD_r[0] <= samp_r[0];
      sampD_r[1] <= samp_r[1];
      for (i = 0; i < 4; i = i + 1) begin
        prodI_r[i] <= mix(samp_r[i/2], lo_r[i][15:8]);
        prodQ_r[i] <= mix(samp_r[i/2], lo_r[i][7:0]);
      end
    end
  end

  // stage 3: block decimator, or straight bypass
  reg [26:0] accI_r [0:3];
  reg [26:0] accQ_r [0:3];
  reg [5:0] decCnt_r;
  reg [95:0] decOut_r;
  reg decValid_r;
  reg [26:0] sumI [0:3];
  reg [26:0] sumQ [0:3];
  wire dump;
  integer k;
  assign dump = (decCnt_r == factor - 6'h01);
  // running block sums, one per mixer product
  always @* begin
    for (k = 0; k < 4; k = k + 1) begin
      sumI[k] = accI_r[k] + {{5{prodI_r[k][21]}}, prodI_r[k]};
      sumQ[k] = accQ_r[k] + {{5{prodQ_r[k][21]}}, prodQ_r[k]};
    end
  end
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        accI_r[i] <= 27'h0000000;
        accQ_r[i] <= 27'h0000000;
      end
      decCnt_r <= 6'h00;
      decOut_r <= 96'h0;
      decValid_r <= 1'b0;
      flush_r <= 2'h0;
    end else if (bypass || initS) begin
      decCnt_r <= 6'h00;
      decValid_r <= bypass;
      decOut_r <= {24'h000000, sampD_r[1][13:2], 12'h000, 24'h000000, sampD_r[0][13:2], 12'h000};
      flush_r <= 2'h0;
    end else begin
      decCnt_r <= dump ? 6'h00 : decCnt_r + 6'h01;
      decValid_r <= dump && (flush_r == 2'h0);
      flush_r <= (dump ? 2'h0 : flush_r) | switched;
      for (i = 0; i < 4; i = i + 1) begin
        accI_r[i] <= dump ? 27'h0000000 : sumI[i];
        accQ_r[i] <= dump ? 27'h0000000 : sumQ[i];
        if (dump)
          decOut_r[24*i +: 24] <= {sumI[i][`OUT_MSB:`OUT_LSB], sumQ[i][`OUT_MSB:`OUT_LSB]};
      end
    end
  end

  // latency ring trims every option to its fixed total
  reg [96:0] ring [0:2047];
  reg [10:0] wp_r;
  reg [10:0] fill_r;
  reg [95:0] ringData_r;
  reg ringValid_r;
  wire [11:0] latCyc;
  wire [10:0] ringOff;
  wire [96:0] ringRd;
  assign latCyc = (latX2(dec_r[3:0]) + 12'h001) >> 1;
  assign ringOff = latCyc[10:0] - `PIPE_CYC;
  assign ringRd = ring[wp_r - ringOff];
  always @(posedge sys_clk) begin
    ring[wp_r] <= {decValid_r, decOut_r};
  end
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wp_r <= 11'h000;
      fill_r <= 11'h000;
      ringData_r <= 96'h0;
      ringValid_r <= 1'b0;
    end else begin
      wp_r <= wp_r + 11'h001;
      if (fill_r != 11'h7ff)
        fill_r <= fill_r + 11'h001;
      ringData_r <= ringRd[95:0];
      ringValid_r <= ringRd[96] && (fill_r > ringOff + `RING_WARM);
    end
  end

  // channel B converter power-down in multiplexer mode
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      chBPowerDown <= 1'b0;
    else
      chBPowerDown <= muxMode & mux_r[1];
  end

  // 32-word buffer toward the lane framer
  ddcn_fifo #(.W(96), .DEPTH(32), .AW(5)) outFifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .inValid(ringValid_r),
    .inData(ringData_r),
    .inReady(streamReady),
    .outValid(linkValid),
    .outData(linkData),
    .outReady(linkReady)
  );
endmodule // ddcn_top
`default_nettype wire

/* ddcn_top_chk.sv */
`default_nettype none
module ddcn_top_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic spiSenN,
  input wire logic spiSdoutEn,
  input wire logic linkReady,
  input wire logic [95:0] linkData,
  input wire logic linkValid,
  input wire logic streamReady,
  input wire logic chBPowerDown
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] sinceRst_r;
  // cycles since reset release, saturating
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sinceRst_r <= 11'h000;
    end else if (sinceRst_r != 11'h7ff) begin
      sinceRst_r <= sinceRst_r + 11'h001;
    end
  end
  // outputs quiet in reset, stream words only after the pipeline has filled
  a_reset_quiet: assert property (@(posedge sys_clk) !resetn |-> !linkValid && !streamReady && !chBPowerDown)
    else $error("outputs active during reset");
  a_first_late: assert property (@(posedge sys_clk) disable iff (!resetn) linkValid |-> sinceRst_r >= 11'h1a8)
    else $error("stream word earlier than the bypass latency");
  // a word on offer stands until the framer takes it
  a_valid_holds: assert property (@(posedge sys_clk) disable iff (!resetn) linkValid && !linkReady |=> linkValid)
    else $error("stream word withdrawn before accepted");
  a_data_holds: assert property (@(posedge sys_clk) disable iff (!resetn) linkValid && !linkReady |=> $stable(linkData))
    else $error("stream data changed before accepted");
  a_ready_after: assert property (@(posedge sys_clk) disable iff (!resetn) $rose(resetn) |-> ##1 streamReady)
    else $error("buffer not ready after reset");
  // control changes only inside a serial frame
  a_pd_on_write: assert property (@(posedge sys_clk) disable iff (!resetn) $changed(chBPowerDown) |-> !spiSenN)
    else $error("power down changed outside a frame");
  a_sdout_framed: assert property (@(posedge sys_clk) disable iff (!resetn) $rose(spiSdoutEn) |-> !spiSenN)
    else $error("read data driven while deselected");
  a_sdout_ends: assert property (@(posedge sys_clk) disable iff (!resetn) spiSenN [*5] |-> !spiSdoutEn)
    else $error("read data still driven after deselect");
endmodule // ddcn_top_chk

bind ddcn_top ddcn_top_chk chk_u (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .spiSenN(spiSenN),
  .spiSdoutEn(spiSdoutEn),
  .linkReady(linkReady),
  .linkData(linkData),
  .linkValid(linkValid),
  .streamReady(streamReady),
  .chBPowerDown(chBPowerDown)
);
`default_nettype wire

/* ddcn_link_rx.sv */
`default_nettype none
module ddcn_link_rx (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic linkValid,
  input wire logic [1:0] rxMode,
  output logic linkReady,
  output logic [15:0] rxWords
);
  timeunit 1ns;
  timeprecision 100ps;
  // mode 0 prompt, 1 stalled, 2 every other cycle; counts accepted words
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      linkReady <= 1'b0;
      rxWords <= 16'h0000;
    end else begin
      linkReady <= rxMode == 2'h0 || (rxMode == 2'h2 && !linkReady);
      if (linkValid && linkReady) begin
        rxWords <= rxWords + 16'h0001;
      end
    end
  end
endmodule // ddcn_link_rx
`default_nettype wire

/* test_ddc_nco_mixer_select.sv */
`include "ddcn_map.vh"
`default_nettype none
module test_ddc_nco_mixer_select;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic resetn = 1'b1;
  logic spiSclk = 1'b0;
  logic spiSenN = 1'b1;
  logic spiSdin = 1'b0;
  logic [3:0] gpioPin = 4'h0;
  logic linkInit = 1'b0;
  logic [13:0] adcA = 14'h0000;
  logic [13:0] adcB = 14'h0000;
  logic [1:0] rxMode = 2'h0;
  logic spiSdout;
  logic spiSdoutEn;
  logic linkReady;
  logic [95:0] linkData;
  logic linkValid;
  logic streamReady;
  logic chBPowerDown;
  logic [15:0] rxWords;
  logic [15:0] w0;
  logic [7:0] q;
  int failures = 0;
  int check_count = 0;
  logic [14:0] regs [6] = '{`ADDR_A_SRC, `ADDR_A_CHOICE, `ADDR_A_PINMAP, `ADDR_B_SRC, `ADDR_B_CHOICE, `ADDR_B_PINMAP};
  // address, write data, read mask, expected read
  logic [38:0] rows [7] = '{
    {`ADDR_A_CHOICE, 8'h01, 8'h03, 8'h01},
    {`ADDR_A_CHOICE, 8'h02, 8'h03, 8'h02},
    {`ADDR_A_CHOICE, 8'h03, 8'h03, 8'h02},
    {`ADDR_B_CHOICE, 8'h02, 8'h03, 8'h02},
    {`ADDR_B_CHOICE, 8'h00, 8'h03, 8'h00},
    {15'h1234, 8'h55, 8'hff, 8'h00},
    {`ADDR_MUX, 8'h03, 8'h03, 8'h03}};

  always #2.5 sys_clk = ~sys_clk;

  ddcn_top dut_u (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .spiSclk(spiSclk),
    .spiSenN(spiSenN),
    .spiSdin(spiSdin),
    .spiSdout(spiSdout),
    .spiSdoutEn(spiSdoutEn),
    .gpioPin(gpioPin),
    .linkInit(linkInit),
    .adcA(adcA),
    .adcB(adcB),
    .linkReady(linkReady),
    .linkData(linkData),
    .linkValid(linkValid),
    .streamReady(streamReady),
    .chBPowerDown(chBPowerDown)
  );

  ddcn_link_rx rx_u (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .linkValid(linkValid),
    .rxMode(rxMode),
    .linkReady(linkReady),
    .rxWords(rxWords)
  );

  task automatic wrap_up;
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input logic [95:0] got, input logic [95:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one 24-bit frame, half sclk period of five clocks; read bits sampled before each rise
  task automatic spi(input logic rd, input logic [14:0] a, input logic [7:0] d, output logic [7:0] r);
    logic [23:0] f;
    f = {rd, a, d};
    r = 8'h00;
    spiSenN <= 1'b0;
    repeat (5) @(posedge sys_clk);
    for (int i = 23; i >= 0; i--) begin
      spiSdin <= f[i];
      repeat (5) @(posedge sys_clk);
      if (i < 8) r[i] = spiSdout;
      spiSclk <= 1'b1;
      repeat (5) @(posedge sys_clk);
      spiSclk <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    spiSenN <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask

  // pin number (bit of gpioPin) picked by a route code
  function automatic logic [1:0] pb(input logic [1:0] c);
    return c == 2'h0 ? 2'h3 : c == 2'h1 ? 2'h0 : c == 2'h2 ? 2'h2 : 2'h1;
  endfunction

  // single-sample impulse through the bypass path, counted edge by edge
  task automatic pulse(input logic [11:0] expB);
    int n;
    @(posedge sys_clk);
    adcA <= 14'h1abc;
    adcB <= 14'h0155;
    @(posedge sys_clk);
    adcA <= 14'h0000;
    adcB <= 14'h0000;
    n = 1;
    while (linkData[23:12] === 12'h000 && n < 1000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    cmp(n, 424);
    cmp(linkData[71:60], expB);
    cmp({linkData[95:72], linkData[59:24], linkData[11:0]}, 96'h0);
  endtask

  initial begin
    resetn <= 1'b0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    foreach (regs[i]) begin
      spi(1'b1, regs[i], 8'h00, q);
      cmp(q, 8'h00);
    end
    foreach (rows[i]) begin
      spi(1'b0, rows[i][38:24], rows[i][23:16], q);
      spi(1'b1, rows[i][38:24], 8'h00, q);
      cmp(q & rows[i][15:8], rows[i][7:0]);
    end
    cmp(chBPowerDown, 1'b1);
    // pin-driven hopping on both channels, every route code
    for (int ch = 0; ch < 2; ch++) begin
      spi(1'b0, ch ? `ADDR_B_SRC : `ADDR_A_SRC, 8'h01, q);
      for (int c = 0; c < 4; c++) begin
        spi(1'b0, ch ? `ADDR_B_PINMAP : `ADDR_A_PINMAP, {4'h0, ~c[1:0], c[1:0]}, q);
        gpioPin <= 4'h1 << pb(c[1:0]);
        spi(1'b1, ch ? `ADDR_B_CHOICE : `ADDR_A_CHOICE, 8'h00, q);
        cmp(q[1:0], 2'h1);
        gpioPin <= 4'h1 << pb(~c[1:0]);
        spi(1'b1, ch ? `ADDR_B_CHOICE : `ADDR_A_CHOICE, 8'h00, q);
        cmp(q[1:0], 2'h2);
        gpioPin <= 4'hf;
        spi(1'b1, ch ? `ADDR_B_CHOICE : `ADDR_A_CHOICE, 8'h00, q);
        cmp(q[1:0], 2'h2);
      end
      spi(1'b0, ch ? `ADDR_B_SRC : `ADDR_A_SRC, 8'h00, q);
    end
    spi(1'b0, `ADDR_MUX, 8'h01, q);
    cmp(chBPowerDown, 1'b0);
    pulse(12'h6af);
    spi(1'b0, `ADDR_MUX, 8'h00, q);
    pulse(12'h055);
    // framer stalls, then trickles, then takes a word every cycle
    rxMode <= 2'h1;
    repeat (100) @(posedge sys_clk);
    cmp(streamReady, 1'b0);
    rxMode <= 2'h2;
    repeat (100) @(posedge sys_clk);
    rxMode <= 2'h0;
    repeat (100) @(posedge sys_clk);
    cmp(streamReady, 1'b1);
    // divide-by-8 with a tuned oscillator, link restarted for a fixed phase
    spi(1'b0, `ADDR_A_FREQ, 8'h00, q);
    spi(1'b0, `ADDR_A_FREQ + 15'h0001, 8'h10, q);
    spi(1'b0, `ADDR_DEC, {4'h0, `DEC_DIV8}, q);
    linkInit <= 1'b1;
    repeat (4) @(posedge sys_clk);
    linkInit <= 1'b0;
    adcA <= 14'h0800;
    repeat (1000) @(posedge sys_clk);
    #1;
    w0 = rxWords;
    repeat (800) @(posedge sys_clk);
    #1;
    cmp(rxWords - w0, 16'd100);
    spi(1'b0, `ADDR_DEC, 8'h01, q);
    repeat (1000) @(posedge sys_clk);
    #1;
    cmp({linkData[95:72], linkData[47:24]}, 48'h0);
    wrap_up();
  end

  // watchdog well beyond the expected run
  initial begin
    #250000;
    failures++;
    wrap_up();
  end
endmodule // test_ddc_nco_mixer_select
`default_nettype wire
